// ==== rtl/sram_host.sv ====
// Purpose: Host sequencer driving an asynchronous 16-bit static memory
// Assumes: Inputs synchronous to ref_clk; one access at a time
// Notes: Each access asserts selects, then releases all strobes together
`timescale 1ns/100ps
module sram_host
  import sram_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic idle_standby,
  output logic [ADDR_W-1:0] mem_addr,
  output strobes_t mem_ctl,
  input wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  state_t state;
  // Cycle counter within a phase
  logic [CNT_W-1:0] cnt;
  // Current access kind and lanes
  logic is_write;
  logic [1:0] lanes;
  // Registered pin values
  logic active;

  // Phase has run its full length
  wire logic rd_done = (state == ST_READ) && (cnt == CNT_W'(RD_CYC - 1));
  wire logic wr_done = (state == ST_WRITE) && (cnt == CNT_W'(WR_CYC - 1));
  wire logic turn_done = (state == ST_TURN) && (cnt == CNT_W'(HZ_CYC - 1));
  // Accept only from idle
  assign req_ready = (state == ST_IDLE);
  wire logic take = req_ready && req_valid && clk_en;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, decoded from registered state
  // One assignment drives the whole strobe carrier, so no member
  // ever has a second driver
  assign mem_ctl = '{
    sel_n: ~active,
    sel: active,
    // Strobe low only in write phase
    we_n: ~(active && is_write),
    oe_n: ~(active && !is_write),
    // Lanes off between accesses for standby
    upper_lane_sel_n: ~(active && lanes[1]),
    lower_lane_sel_n: ~(active && lanes[0])
  };
  // Standby shown when no access runs
  assign idle_standby = ~active;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      active <= 1'b0;
      is_write <= 1'b0;
      lanes <= 2'h0;
      mem_addr <= '0;
      mem_dq_out <= '0;
      mem_dq_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          // Address set with select, same edge
          if (take)
          begin
            state <= req.write ? ST_WRITE : ST_READ;
            mem_addr <= req.addr;
            mem_dq_out <= req.wdata;
            mem_dq_oe <= req.write;
            is_write <= req.write;
            lanes <= (req.lanes == 2'h0) ? 2'h3 : req.lanes;
            active <= 1'b1;
            cnt <= '0;
          end
        end
        ST_READ:
        begin
          cnt <= cnt + 1'b1;
          if (rd_done)
          begin
            rsp_data <= mem_dq_in;
            rsp_valid <= 1'b1;
            active <= 1'b0;
            state <= ST_TURN;
            cnt <= '0;
          end
        end
        ST_WRITE:
        begin
          cnt <= cnt + 1'b1;
          if (wr_done)
          begin
            // All strobes end the write together
            active <= 1'b0;
            rsp_valid <= 1'b1;
            state <= ST_TURN;
            cnt <= '0;
          end
        end
        ST_TURN:
        begin
          // Data held one cycle past write end
          mem_dq_oe <= 1'b0;
          cnt <= cnt + 1'b1;
          if (turn_done)
          begin
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Enabled cycles with output enable low, saturating; a counter
  // keeps the read length check free of a long repetition
  logic [CNT_W-1:0] oe_run;

  // Run length of the read strobe, frozen with the rest of the block
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      oe_run <= '0;
    end
    else if (clk_en)
    begin
      if (mem_ctl.oe_n)
      begin
        oe_run <= '0;
      end
      else if (oe_run != '1)
      begin
        oe_run <= oe_run + 1'b1;
      end
    end
  end

  // Read strobes stay on for the whole access time
  a_read_length: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(mem_ctl.oe_n) |-> (oe_run >= CNT_W'(RD_CYC)))
    else $error("read strobes released early");
  // No write strobe while outputs are on
  a_we_high_read: assert property (
    @(posedge ref_clk) disable iff (rst)
    !mem_ctl.oe_n |-> mem_ctl.we_n)
    else $error("write strobe low during read");
  // Host off the bus whenever the memory drives it
  a_no_bus_fight: assert property (
    @(posedge ref_clk) disable iff (rst)
    !mem_ctl.oe_n |-> !mem_dq_oe)
    else $error("host drives bus with outputs on");
  // Address frozen for as long as an access runs
  a_addr_stable: assert property (
    @(posedge ref_clk) disable iff (rst)
    (active && $past(active)) |-> $stable(mem_addr))
    else $error("address moved inside access");
  // Data driven with the strobe and held after its first cycle
  a_data_setup: assert property (
    @(posedge ref_clk) disable iff (rst)
    !mem_ctl.we_n |->
      (mem_dq_oe && ($past(mem_ctl.we_n) || $stable(mem_dq_out))))
    else $error("write data not held during strobe");
  // Write strobe only with both selects and a lane on
  a_write_select: assert property (
    @(posedge ref_clk) disable iff (rst)
    !mem_ctl.we_n |-> (!mem_ctl.sel_n && mem_ctl.sel &&
      !(mem_ctl.upper_lane_sel_n && mem_ctl.lower_lane_sel_n)))
    else $error("write strobe without full qualification");
  // Active-low select and upper lane drop with the write strobe
  a_write_end: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(mem_ctl.we_n) |-> mem_ctl.sel_n && mem_ctl.upper_lane_sel_n)
    else $error("write not ended cleanly");
  // Idle keeps the memory in standby
  a_standby_idle: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state == ST_IDLE) |-> (mem_ctl.upper_lane_sel_n &&
      mem_ctl.lower_lane_sel_n && mem_ctl.sel_n))
    else $error("lanes left on while idle");
endmodule : sram_host

// ==== rtl/sram_host_pkg.sv ====
// Purpose: Shared constants and carriers for the async static memory host
// Assumes: 100 MHz ref_clk, 10 ns period
// Notes: Timing figures in ns, cycle counts derived below
package sram_host_pkg;
  // Clock period in ns
  localparam int CLK_NS = 10;
  // Speed grade selector: 1 picks the fast part
  localparam bit FAST_GRADE = 1'b0;
  // Read access time (address to data)
  localparam int T_AA_NS = FAST_GRADE ? 45 : 55;
  // Output enable to data valid
  localparam int T_DOE_NS = FAST_GRADE ? 22 : 25;
  // Output float after a strobe goes high
  localparam int T_HZ_NS = FAST_GRADE ? 18 : 20;
  // Address and lane setup to write end
  localparam int T_AW_NS = FAST_GRADE ? 35 : 40;
  // Data setup to write end
  localparam int T_SD_NS = 25;
  // Least times round up to whole cycles
  localparam int RD_CYC = (T_AA_NS + CLK_NS - 1) / CLK_NS;
  localparam int PW_MIN = (T_AW_NS + CLK_NS - 1) / CLK_NS;
  localparam int PW_OE = (T_SD_NS + T_HZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (PW_MIN > PW_OE) ? PW_MIN : PW_OE;
  localparam int HZ_CYC = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
  // Counter width
  localparam int CNT_W = 4;
  // Pin widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // States of the access sequencer
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_TURN = 3'b011
  } state_t;

  // Memory-side strobes, all as seen on the pins
  typedef struct packed
  {
    logic sel_n;
    logic sel;
    logic we_n;
    logic oe_n;
    logic upper_lane_sel_n;
    logic lower_lane_sel_n;
  } strobes_t;

  // Request carrier from the user side
  typedef struct packed
  {
    logic write;
    logic [1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;
endpackage : sram_host_pkg

// ==== testbench/sram_model.sv ====
// Purpose: Behavioural static memory on the host pins
// Assumes: Pins as driven by the host, no clock
// Notes: Floated lanes show the inverted byte, never a held value
`timescale 1ns/100ps
module sram_model
  import sram_host_pkg::*;
(
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire strobes_t mem_ctl,
  input wire logic [DATA_W-1:0] mem_dq_out,
  output logic [DATA_W-1:0] mem_dq_in
);
  // Storage array
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  // Word at the pins
  logic [DATA_W-1:0] cur;
  wire ce = !mem_ctl.sel_n && mem_ctl.sel;
  wire up = ce && !mem_ctl.upper_lane_sel_n;
  wire lo = ce && !mem_ctl.lower_lane_sel_n;
  wire rd = mem_ctl.we_n && !mem_ctl.oe_n;
  ////////////////////////////////////////////////////////////////////
  // write in full overlap only, no write-back
  always @*
    if (!mem_ctl.we_n && (up || lo))
    begin
      if (up) mem[mem_addr][15:8] = mem_dq_out[15:8];
      if (lo) mem[mem_addr][7:0] = mem_dq_out[7:0];
    end
  assign cur = mem[mem_addr];
  assign #T_HZ_NS mem_dq_in = {rd && up ? cur[15:8] : ~cur[15:8],
    rd && lo ? cur[7:0] : ~cur[7:0]};
endmodule : sram_model

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the static memory host
// Assumes: Slow grade counts from the package
// Notes: Row table first, then freeze and mid-access reset
`timescale 1ns/100ps
module testbench;
  import sram_host_pkg::*;
  typedef struct packed {req_t r; logic [DATA_W-1:0] exp;} row_t;
  logic ref_clk = 0, rst = 1, clk_en = 1, req_valid = 0;
  req_t req = '0;
  logic req_ready, rsp_valid, idle_standby, mem_dq_oe;
  logic [DATA_W-1:0] rsp_data, mem_dq_in, mem_dq_out;
  logic [ADDR_W-1:0] mem_addr;
  strobes_t mem_ctl;
  int num_errors = 0, checks_done = 0, cycles = 0, lat;
  row_t rows [8];
  sram_host dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .idle_standby(idle_standby), .mem_addr(mem_addr),
    .mem_ctl(mem_ctl), .mem_dq_in(mem_dq_in),
    .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
  sram_model far (.mem_addr(mem_addr), .mem_ctl(mem_ctl),
    .mem_dq_out(mem_dq_out), .mem_dq_in(mem_dq_in));
  initial forever #5 ref_clk = ~ref_clk;
  // Hang guard, far above the ninety-odd cycles needed
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One access; pins watched at each falling edge
  task automatic do_op(input req_t r);
    logic tk;
    tk = 1'b0;
    @(posedge ref_clk);
    req <= r;
    req_valid <= 1'b1;
    while (tk !== 1'b1)
    begin
      @(negedge ref_clk);
      tk = req_ready;
      @(posedge ref_clk);
    end
    req_valid <= 1'b0;
    lat = 0;
    repeat (20)
    begin
      @(negedge ref_clk);
      if (rsp_valid === 1'b1) break;
      if (mem_ctl.sel_n === 1'b0)
      begin
        chk("addr", 32'(r.addr), 32'(mem_addr));
        chk("lanes", {30'h0, ~((r.lanes == 2'b00) ? 2'b11 : r.lanes)},
          {30'h0, mem_ctl.upper_lane_sel_n,
          mem_ctl.lower_lane_sel_n});
        if (r.write)
          chk("wdata", {15'h0, 1'b1, r.wdata},
            {15'h0, mem_dq_oe, mem_dq_out});
        else
          chk("rd_pins", 32'h2, {mem_ctl.we_n, mem_dq_oe});
      end
      @(posedge ref_clk);
      lat++;
    end
  endtask : do_op
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    // Lane writes merge bytes; lanes 0 means both
    rows[0] = '{'{1'b1, 2'b11, 19'h00000, 16'h1234}, 16'h0};
    rows[1] = '{'{1'b0, 2'b11, 19'h00000, 16'h0}, 16'h1234};
    rows[2] = '{'{1'b1, 2'b01, 19'h00000, 16'habcd}, 16'h0};
    rows[3] = '{'{1'b0, 2'b11, 19'h00000, 16'h0}, 16'h12cd};
    rows[4] = '{'{1'b1, 2'b10, 19'h00000, 16'h5600}, 16'h0};
    rows[5] = '{'{1'b0, 2'b00, 19'h00000, 16'h0}, 16'h56cd};
    rows[6] = '{'{1'b1, 2'b00, 19'h7ffff, 16'hbeef}, 16'h0};
    rows[7] = '{'{1'b0, 2'b11, 19'h7ffff, 16'h0}, 16'hbeef};
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      do_op(rows[i].r);
      chk("latency", rows[i].r.write ? WR_CYC : RD_CYC, lat);
      if (!rows[i].r.write) chk("rdata", rows[i].exp, 32'(rsp_data));
      $display("row %0d done", i);
    end
    // Clock enable low in idle: request must not be taken
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b0;
    req <= rows[1].r;
    req_valid <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("frozen", 32'h1af, {req_ready, idle_standby, rsp_valid,
      mem_ctl});
    @(posedge ref_clk);
    clk_en <= 1'b1;
    req_valid <= 1'b0;
    $display("freeze test done");
    // Reset in mid-write drops all strobes at once
    @(posedge ref_clk);
    req <= '{1'b1, 2'b11, 19'h00005, 16'h9999};
    req_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    req_valid <= 1'b0;
    rst <= 1'b1;
    @(negedge ref_clk);
    chk("reset", 32'h32f, {req_ready, idle_standby, rsp_valid,
      mem_dq_oe, mem_ctl});
    @(posedge ref_clk);
    rst <= 1'b0;
    do_op(rows[5].r);
    chk("rdata", 32'h56cd, 32'(rsp_data));
    $display("reset test done");
    finish_test();
  end
endmodule : testbench
